// [cke_zq_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
module cke_zq_monitor (
    input wire logic        sys_clk,
    input wire logic        reset,
    input wire logic        cfg_wr,
    input wire logic [7:0]  cfg_addr,
    input wire logic [31:0] cfg_wdata,
    input wire logic        cke_shared,
    input wire logic [3:0]  rank_req_pending,
    input wire logic [3:0]  sr_exit,
    input wire logic [3:0]  short_cal_sent,
    input wire logic [3:0]  long_cal_sent,
    input wire logic [3:0]  cke,
    input wire logic [3:0]  pd_entry_req,
    input wire logic        pd_slow_exit,
    input wire logic [3:0]  short_cal_req,
    input wire logic [3:0]  cmd_ok,
    input wire logic [3:0]  dll_cmd_ok
);
    logic [31:0] cke_q;
    logic [31:0] cal_q;
    logic        prev_q;
    logic [3:0]  hold_q;
    // Shadow copies let the hold-off checks use the live field values
    always_ff @(posedge sys_clk) begin
        prev_q <= cke[0];
        // Starts saturated so the first level after reset is never judged too short
        if (reset) hold_q <= 4'hf;
        else hold_q <= (cke[0] != prev_q) ? 4'h1 : hold_q + {3'h0, hold_q != 4'hf};
        if (reset) begin
            cke_q <= 32'h0;
            cal_q <= 32'h6040_1a80;
        end else if (cfg_wr && cfg_addr == 8'h90) begin
            cke_q <= cfg_wdata;
        end else if (cfg_wr && cfg_addr == 8'h94) begin
            cal_q <= cfg_wdata;
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    sequence sr_start;
        sr_exit[0] && cke_q[10:3] != 8'h0;
    endsequence
    sequence both_held;
        !cmd_ok[0] && !dll_cmd_ok[0];
    endsequence
    sequence zqcs_go;
        short_cal_sent[0] && !long_cal_sent[0] && cal_q[7:5] != 3'h0;
    endsequence
    chk_no_slow_exit: assert property (pd_slow_exit == 1'b0)
        else $error("slow exit selected");
    chk_entry_fall: assert property (pd_entry_req[0] |-> $fell(cke[0]))
        else $error("entry pulse without cke fall");
    chk_entry_idle: assert property (pd_entry_req[0] |-> !$past(rank_req_pending[0]))
        else $error("entry with request pending");
    chk_shared_pair: assert property (cke_shared |-> cke[0] == cke[1] && cke[2] == cke[3])
        else $error("shared cke pair split");
    chk_pulse_width: assert property ($changed(cke[0]) |-> hold_q >= {1'b0, cke_q[2:0]})
        else $error("cke level too short");
    chk_pd_exit: assert property ($rose(cke[0]) && cke_q[23:21] != 3'h0 |-> !cmd_ok[0])
        else $error("command allowed at exit");
    chk_sr_hold: assert property (sr_start |=> both_held)
        else $error("command allowed after self-refresh exit");
    chk_zqcs_hold: assert property (zqcs_go |=> !cmd_ok[0] [*8])
        else $error("short calibration hold too short");
    chk_zqcl_hold: assert property (long_cal_sent[3] && cal_q[4:0] != 5'h0 |=> !cmd_ok[3] [*8])
        else $error("long calibration hold too short");
    chk_cal_serial: assert property (!cal_q[30] |-> $onehot0(short_cal_req))
        else $error("parallel calibration while serial");
endmodule
bind ddr3_cke_zq_timing_ctrl cke_zq_monitor cke_zq_monitor_inst (.sys_clk, .reset, .cfg_wr,
    .cfg_addr, .cfg_wdata, .cke_shared, .rank_req_pending, .sr_exit, .short_cal_sent,
    .long_cal_sent, .cke, .pd_entry_req, .pd_slow_exit, .short_cal_req, .cmd_ok, .dll_cmd_ok);
`default_nettype wire

// [ddr3_cke_zq_consts.vh]
`ifndef DDR3_CKE_ZQ_CONSTS_VH
`define DDR3_CKE_ZQ_CONSTS_VH

// Register offsets on the dword configuration port
`define CKE_TIMING_OFFSET   8'h90
`define CAL_TIMING_OFFSET   8'h94

// Clock-enable timing fields
`define F_RANK_IDLE         31:24
`define F_PD_EXIT           23:21
`define F_SR_EXIT_LOCKED    20:11
`define F_SR_EXIT           10:3
`define F_CKE_PULSE         2:0

// Calibration timing fields
`define F_PARALLEL_CAL      30
`define F_PERIODIC_EN       29
`define F_CAL_INTERVAL      28:8
`define F_SHORT_CAL         7:5
`define F_LONG_CAL          4:0

// Reset values and writable masks
`define CKE_TIMING_RESET    32'h0000_0000
`define CAL_TIMING_RESET    32'h6040_1a80
`define CKE_TIMING_MASK     32'hffff_ffff
`define CAL_TIMING_MASK     32'h7fff_ffff

// Calibration busy-time multipliers
`define SHORT_CAL_SHIFT     4
`define LONG_CAL_SHIFT      5

// Structure
`define RANKS               4
`define TIMER_W             12

`endif

// [ddr3_cke_zq_timing_ctrl.v]
`timescale 1ns/1ps
`default_nettype none
`include "ddr3_cke_zq_consts.vh"

module ddr3_cke_zq_timing_ctrl (
    input  wire        sys_clk,
    input  wire        reset,
    input  wire        cfg_wr,
    input  wire        cfg_rd,
    input  wire [7:0]  cfg_addr,
    input  wire [31:0] cfg_wdata,
    output reg  [31:0] cfg_rdata,
    input  wire        cke_shared,
    input  wire [3:0]  rank_req_pending,
    input  wire [3:0]  sr_exit,
    input  wire        refi_tick,
    input  wire [3:0]  short_cal_sent,
    input  wire [3:0]  long_cal_sent,
    output wire [3:0]  cke,
    output wire [3:0]  pd_entry_req,
    output wire        pd_slow_exit,
    output wire [3:0]  short_cal_req,
    output wire [3:0]  cmd_ok,
    output wire [3:0]  dll_cmd_ok
);

    reg  [31:0] clock_enable_timing_q;
    reg  [31:0] calibration_timing_q;

    // Field views; timing values count command clocks, except the calibration interval (refresh ticks) and calibration times (x16, x32 clocks)
    wire [7:0]  rank_idle_time;
    wire [2:0]  powerdown_exit_delay;
    wire [9:0]  selfrefresh_exit_locked_delay;
    wire [7:0]  selfrefresh_exit_delay;
    wire [2:0]  cke_min_pulse;
    wire        parallel_calibration;
    wire        periodic_cal_enable;
    wire [20:0] periodic_cal_interval;
    wire [2:0]  short_cal_time;
    wire [4:0]  long_cal_time;
    wire [11:0] short_cal_cycles;
    wire [11:0] long_cal_cycles;

    assign rank_idle_time                = clock_enable_timing_q[`F_RANK_IDLE];
    assign powerdown_exit_delay          = clock_enable_timing_q[`F_PD_EXIT];
    assign selfrefresh_exit_locked_delay = clock_enable_timing_q[`F_SR_EXIT_LOCKED];
    assign selfrefresh_exit_delay        = clock_enable_timing_q[`F_SR_EXIT];
    assign cke_min_pulse                 = clock_enable_timing_q[`F_CKE_PULSE];
    assign parallel_calibration          = calibration_timing_q[`F_PARALLEL_CAL];
    assign periodic_cal_enable           = calibration_timing_q[`F_PERIODIC_EN];
    assign periodic_cal_interval         = calibration_timing_q[`F_CAL_INTERVAL];
    assign short_cal_time                = calibration_timing_q[`F_SHORT_CAL];
    assign long_cal_time                 = calibration_timing_q[`F_LONG_CAL];

    // Field scaled by 16 and 32; the widest result (992) fits the timer width
    assign short_cal_cycles = {5'h00, short_cal_time, 4'h0};
    assign long_cal_cycles  = {2'h0, long_cal_time, 5'h00};

    // Dword configuration port: whole-register writes, registered read data
    always @(posedge sys_clk) begin
        if (reset) begin
            clock_enable_timing_q <= `CKE_TIMING_RESET;
            calibration_timing_q  <= `CAL_TIMING_RESET;
        end else if (cfg_wr) begin
            if (cfg_addr == `CKE_TIMING_OFFSET) begin
                clock_enable_timing_q <= cfg_wdata & `CKE_TIMING_MASK;
            end
            if (cfg_addr == `CAL_TIMING_OFFSET) begin
                calibration_timing_q <= cfg_wdata & `CAL_TIMING_MASK;
            end
        end
    end

    always @(posedge sys_clk) begin
        if (reset) begin
            cfg_rdata <= 32'h0000_0000;
        end else if (cfg_rd) begin
            case (cfg_addr)
                `CKE_TIMING_OFFSET: begin
                    cfg_rdata <= clock_enable_timing_q;
                end
                `CAL_TIMING_OFFSET: begin
                    cfg_rdata <= calibration_timing_q;
                end
                default: begin
                    cfg_rdata <= 32'h0000_0000;
                end
            endcase
        end
    end

    // Only fast-exit precharge power-down is ever requested
    assign pd_slow_exit = 1'b0;

    // Periodic calibration scheduler
    reg  [20:0] interval_cnt_q;
    reg  [3:0]  cal_pending_q;
    wire [3:0]  cal_busy;
    wire        any_cal_busy;
    wire        interval_done;
    reg  [3:0]  cal_grant;
    reg         grant_taken;
    integer     g;

    assign any_cal_busy  = |cal_busy;
    // An interval of zero is treated as one refresh interval
    assign interval_done = refi_tick &&
                           ((interval_cnt_q + 21'h000001) >= periodic_cal_interval);

    always @(posedge sys_clk) begin
        if (reset) begin
            interval_cnt_q <= 21'h000000;
        end else if (!periodic_cal_enable) begin
            interval_cnt_q <= 21'h000000;
        end else if (interval_done) begin
            interval_cnt_q <= 21'h000000;
        end else if (refi_tick) begin
            interval_cnt_q <= interval_cnt_q + 21'h000001;
        end
    end

    // A new round re-arms every rank; a round still in progress keeps its own bits
    always @(posedge sys_clk) begin
        if (reset) begin
            cal_pending_q <= 4'h0;
        end else if (periodic_cal_enable && interval_done) begin
            cal_pending_q <= 4'hf;
        end else begin
            cal_pending_q <= cal_pending_q & ~short_cal_sent;
        end
    end

    // Serial mode hands the request to the lowest pending rank once nobody calibrates
    always @* begin
        cal_grant   = 4'h0;
        grant_taken = 1'b0;
        for (g = 0; g < `RANKS; g = g + 1) begin
            if (parallel_calibration) begin
                cal_grant[g] = cal_pending_q[g] & ~cal_busy[g];
            end else if (cal_pending_q[g] && !grant_taken && !any_cal_busy) begin
                cal_grant[g] = 1'b1;
                grant_taken  = 1'b1;
            end
        end
    end

    // Per-rank power management and command gating
    wire [3:0] rank_idle;
    wire [3:0] rank_wake;
    wire [3:0] cke_busy;
    wire [3:0] pd_exit_busy;
    wire [3:0] sr_busy;
    wire [3:0] sr_locked_busy;
    wire [3:0] rank_ready;
    wire [3:0] cke_q;
    wire [3:0] pd_entry_q;

    // Pending calibration keeps a rank awake so the command can reach it
    assign rank_wake = rank_req_pending | cal_pending_q;

    genvar r;
    generate
        for (r = 0; r < `RANKS; r = r + 1) begin : rank_gen
            reg  [7:0] idle_cnt_q;
            reg        cke_level_q;
            reg        entry_pulse_q;
            wire       pair_ready;
            wire       pair_pulse_done;
            wire       partner_idle;
            wire       partner_wake;
            wire       group_idle;
            wire       group_wake;
            wire       enter_pd;
            wire       exit_pd;
            wire       cal_load;
            wire [11:0] cal_value;

            always @(posedge sys_clk) begin
                if (reset) begin
                    idle_cnt_q <= 8'h00;
                end else if (rank_wake[r]) begin
                    idle_cnt_q <= 8'h00;
                end else if (idle_cnt_q < rank_idle_time) begin
                    idle_cnt_q <= idle_cnt_q + 8'h01;
                end
            end

            assign rank_idle[r] = !rank_wake[r] && (idle_cnt_q >= rank_idle_time);

            // Ranks pair up as 0/1 and 2/3 behind a shared clock-enable
            assign partner_idle = rank_idle[r ^ 1];
            assign partner_wake = rank_wake[r ^ 1];
            assign group_idle   = rank_idle[r] && (!cke_shared || partner_idle);
            assign group_wake   = rank_wake[r] || (cke_shared && partner_wake);

            // No entry while any exit or calibration hold-off is still running
            assign rank_ready[r] = !cke_busy[r] && !pd_exit_busy[r] && !sr_busy[r] &&
                                   !sr_locked_busy[r] && !cal_busy[r];
            // A shared pin moves only when both ranks may move, or the pair would split
            assign pair_ready      = rank_ready[r] && (!cke_shared || rank_ready[r ^ 1]);
            assign pair_pulse_done = !cke_busy[r] && (!cke_shared || !cke_busy[r ^ 1]);
            assign enter_pd = cke_q[r] && group_idle && pair_ready;
            assign exit_pd  = !cke_q[r] && group_wake && pair_pulse_done;

            // Two flops per rank (cke level and entry pulse); the vectors are wires so each bit has a single driver
            always @(posedge sys_clk) begin
                if (reset) begin
                    cke_level_q   <= 1'b1;
                    entry_pulse_q <= 1'b0;
                end else begin
                    entry_pulse_q <= enter_pd;
                    if (enter_pd) begin
                        cke_level_q <= 1'b0;
                    end else if (exit_pd) begin
                        cke_level_q <= 1'b1;
                    end
                end
            end

            assign cke_q[r]      = cke_level_q;
            assign pd_entry_q[r] = entry_pulse_q;

            hold_timer cke_pulse_timer (
                .sys_clk    (sys_clk),
                .reset      (reset),
                .load       (enter_pd || exit_pd),
                .load_value ({9'h000, cke_min_pulse}),
                .busy       (cke_busy[r])
            );

            // Covers every power-down exit alike; only DLL-on fast exit is ever used
            hold_timer pd_exit_timer (
                .sys_clk    (sys_clk),
                .reset      (reset),
                .load       (exit_pd),
                .load_value ({9'h000, powerdown_exit_delay}),
                .busy       (pd_exit_busy[r])
            );

            hold_timer sr_exit_timer (
                .sys_clk    (sys_clk),
                .reset      (reset),
                .load       (sr_exit[r]),
                .load_value ({4'h0, selfrefresh_exit_delay}),
                .busy       (sr_busy[r])
            );

            hold_timer sr_locked_timer (
                .sys_clk    (sys_clk),
                .reset      (reset),
                .load       (sr_exit[r]),
                .load_value ({2'h0, selfrefresh_exit_locked_delay}),
                .busy       (sr_locked_busy[r])
            );

            // A new sent pulse reloads the timer, so back-to-back calibrations extend the hold
            // Long calibration's hold is loaded if both arrive together, even when it is the shorter
            assign cal_load  = short_cal_sent[r] || long_cal_sent[r];
            assign cal_value = long_cal_sent[r] ? long_cal_cycles : short_cal_cycles;

            hold_timer cal_timer (
                .sys_clk    (sys_clk),
                .reset      (reset),
                .load       (cal_load),
                .load_value (cal_value),
                .busy       (cal_busy[r])
            );

            assign cmd_ok[r]        = cke_q[r] && !pd_exit_busy[r] && !sr_busy[r] &&
                                      !cal_busy[r];
            assign dll_cmd_ok[r]    = cmd_ok[r] && !sr_locked_busy[r];
            assign short_cal_req[r] = cal_grant[r] && cke_q[r] && cmd_ok[r];
        end
    endgenerate

    assign cke          = cke_q;
    assign pd_entry_req = pd_entry_q;

endmodule

`default_nettype wire

// [ddr3_cke_zq_timing_ctrl_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module ddr3_cke_zq_timing_ctrl_tb;
    logic        sys_clk, reset, cfg_wr, cfg_rd, cke_shared, refi_tick, slow, pd_slow_exit;
    logic [7:0]  cfg_addr;
    logic [31:0] cfg_wdata, cfg_rdata;
    logic [3:0]  rank_req_pending, sr_exit, short_cal_sent, long_cal_sent, cke;
    logic [3:0]  pd_entry_req, short_cal_req, cmd_ok, dll_cmd_ok;
    int          num_errors, compares, n;
    ddr3_cke_zq_timing_ctrl ddr3_cke_zq_timing_ctrl_inst (.sys_clk, .reset, .cfg_wr, .cfg_rd,
        .cfg_addr, .cfg_wdata, .cfg_rdata, .cke_shared, .rank_req_pending, .sr_exit, .refi_tick,
        .short_cal_sent, .long_cal_sent, .cke, .pd_entry_req, .pd_slow_exit, .short_cal_req,
        .cmd_ok, .dll_cmd_ok);
    ddr3_rank_model ddr3_rank_model_inst (.sys_clk, .slow, .short_cal_req, .short_cal_sent);
    task results;
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task tick;
        @(posedge sys_clk);
        #1;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        cfg_addr = a; cfg_wdata = d; cfg_wr = 1'b1;
        tick; cfg_wr = 1'b0; tick;
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e);
        cfg_addr = a; cfg_rd = 1'b1;
        tick; cfg_rd = 1'b0; tick;
        check(cfg_rdata, e);
    endtask
    // Counts cycles a hold-off keeps a rank blocked, starting now
    task cnt_low(input int sel, input int b, output int c);
        c = 0;
        repeat (1000) begin
            if ((sel ? dll_cmd_ok[b] : cmd_ok[b]) !== 1'b0) break;
            c++; tick;
        end
    endtask
    task wait_entry(output int c);
        c = 0;
        repeat (40) begin
            tick; c++;
            if (pd_entry_req[0] === 1'b1) break;
        end
    endtask
    task t_regs;
        rd(8'h90, 32'h0); rd(8'h94, 32'h6040_1a80);
        rd(8'h98, 32'h0);
        wr(8'h94, 32'hffff_ffff); rd(8'h94, 32'h7fff_ffff);
        wr(8'h94, 32'h0000_0290);
    endtask
    task t_pd;
        wr(8'h90, 32'h0260_4829);
        rank_req_pending = 4'he; tick; tick;
        rank_req_pending = 4'hf; tick;
        rank_req_pending = 4'he;
        wait_entry(n); check(n, 3);
        check(cke, 4'he);
        tick; rank_req_pending = 4'hf; tick;
        check(cke, 4'hf);
        cnt_low(0, 0, n); check(n, 3);
        check(pd_slow_exit, 1'b0);
    endtask
    task t_sr;
        sr_exit = 4'h1; tick; sr_exit = 4'h0;
        cnt_low(0, 0, n); check(n, 5);
        repeat (12) tick;
        sr_exit = 4'h1; tick; sr_exit = 4'h0;
        cnt_low(1, 0, n); check(n, 9);
    endtask
    task t_cal;
        wr(8'h94, 32'h2000_0290);
        refi_tick = 1'b1; tick; refi_tick = 1'b0;
        repeat (3) tick;
        check(short_cal_req, 4'h0);
        refi_tick = 1'b1; tick; refi_tick = 1'b0;
        repeat (50) begin
            #1;
            if (short_cal_sent[0] === 1'b1) break;
            tick;
        end
        tick; check(short_cal_req[1], 1'b0);
        cnt_low(0, 0, n); check(n, 64);
        slow = 1'b1;
        repeat (400) tick;
        check(short_cal_req, 4'h0);
        wr(8'h94, 32'h0000_0290);
        repeat (3) begin
            refi_tick = 1'b1; tick; refi_tick = 1'b0; tick;
            check(short_cal_req, 4'h0);
        end
        wr(8'h94, 32'h6000_0290);
        refi_tick = 1'b1; tick; refi_tick = 1'b0; tick;
        refi_tick = 1'b1; tick; refi_tick = 1'b0;
        check(short_cal_req, 4'hf);
        repeat (100) tick;
        check(short_cal_req, 4'h0);
        long_cal_sent = 4'h8; tick; long_cal_sent = 4'h0;
        cnt_low(0, 3, n); check(n, 512);
    endtask
    task t_shared;
        reset = 1'b1; cke_shared = 1'b1; tick; tick; reset = 1'b0;
        wr(8'h90, 32'h0260_4829);
        rank_req_pending = 4'he;
        repeat (10) tick;
        check(cke, 4'hf);
        rank_req_pending = 4'hc;
        wait_entry(n); check(n, 3);
        check(cke, 4'hc);
    endtask
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    initial begin
        #(25 * 6000);
        num_errors++;
        results;
    end
    initial begin
        reset = 1'b1; cfg_wr = 1'b0; cfg_rd = 1'b0; cfg_addr = 8'h0; cfg_wdata = 32'h0;
        cke_shared = 1'b0; rank_req_pending = 4'hf; sr_exit = 4'h0; refi_tick = 1'b0;
        long_cal_sent = 4'h0; slow = 1'b0; num_errors = 0; compares = 0;
        repeat (20) @(posedge sys_clk);
        #1 reset = 1'b0;
        t_regs; t_pd; t_sr; t_cal; t_shared;
        results;
    end
endmodule
`default_nettype wire

// [ddr3_rank_model.sv]
`timescale 1ns/1ps
`default_nettype none
module ddr3_rank_model (
    input  wire logic       sys_clk,
    input  wire logic       slow,
    input  wire logic [3:0] short_cal_req,
    output var  logic [3:0] short_cal_sent
);
    int         wait_n;
    logic [3:0] pick;
    // One command per cycle, so only the lowest requesting rank is served
    initial begin
        short_cal_sent = 4'h0;
        wait_n = 0;
        pick = 4'h0;
        forever begin
            @(posedge sys_clk);
            #1;
            pick = 4'h0;
            if (short_cal_req == 4'h0) wait_n = 0;
            else if (slow && wait_n < 4) wait_n++;
            else begin
                pick = short_cal_req & ~(short_cal_req - 4'h1);
                wait_n = 0;
            end
            short_cal_sent = pick;
        end
    end
endmodule
`default_nettype wire

// [hold_timer.v]
`timescale 1ns/1ps
`default_nettype none

// Loadable down-counter; busy stays high for exactly load_value cycles after the load edge.
module hold_timer (
    input  wire        sys_clk,
    input  wire        reset,
    input  wire        load,
    input  wire [11:0] load_value,
    output wire        busy
);

    reg [11:0] count_q;
    reg [11:0] count_d;

    always @* begin
        count_d = count_q;
        if (load) begin
            count_d = load_value;
        end else if (count_q != 12'h000) begin
            count_d = count_q - 12'h001;
        end
    end

    always @(posedge sys_clk) begin
        if (reset) begin
            count_q <= 12'h000;
        end else begin
            count_q <= count_d;
        end
    end

    assign busy = (count_q != 12'h000);

endmodule

`default_nettype wire
